// file: src/pirc_top.v
`timescale 1ns/1ps
`include "pirc_regs.vh"

// Overview of operation
// - enable register at 8Ch, eight bits, zero after power-on reset.
// - flag register at 0Ch, zero after power-on; bit 7 comparator, bit 0 overflow.
// - bits 6 and 5 of flags and enables read zero, ignore writes.
// - counter overflow sets bit 0; requests only with enable bit 0.
// - capture event sets bit 1; requests only with enable bit 1.
// - any level change on port c pins 7..4 sets bit 2, gated by enable 2.
// - serial transfer completion sets bit 3, gated by enable 3.
// - pushbutton sets bit 4 by enable 4; never in high-speed crystal mode.
// - comparator trip sets bit 7, level-sensitive, gated by enable 7.
// - flags set regardless of own enable or global enable.
// - hardware never clears a flag; software writes zero to clear.
// - peripheral requests suppressed unless peripheral enable bit 6 set.
// - power control register at 8Eh: power-on and low-voltage flags, reserved bit 7.
// - power-on reset clears power-on flag; other resets leave it.
// - low-voltage detection clears low-voltage flag.
// - low-voltage flag is undefined after power-on reset.
// - peripheral enable one passes unmasked requests, zero blocks all.
// - global enable zero blocks every request to the core.
module pirc_top (
    input  wire        clock,
    input  wire        nrst,
    input  wire        por_n,
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        counter_overflow_event,
    input  wire        capture_event,
    input  wire [3:0]  port_c_upper_pins,
    input  wire        serial_done_event,
    input  wire        pushbutton_input,
    input  wire        high_speed_crystal_mode,
    input  wire        comparator_trip,
    input  wire        low_voltage_detect,
    output reg         core_irq
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0] peripheral_irq_flags_reg;
    reg  [7:0] peripheral_irq_flags_next;
    reg  [7:0] peripheral_irq_enables_reg;
    reg  [7:0] interrupt_control_reg;
    reg        power_on_flag_reg;
    reg        low_voltage_flag_reg;
    reg        reserved_bit_reg;
    reg        ack_reg;
    reg  [7:0] rd_byte;
    wire [7:0] reg_index;
    wire       wr_low;
    wire [7:0] wdat;

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    wire [3:0] pc_sync;
    wire [3:0] pc_change;
    wire [2:0] misc_sync;
    wire [2:0] misc_rise;
    wire       cmp_sync;
    wire       lvd_sync;
    wire       hs_sync;

    pirc_sync #(.WIDTH(6)) u_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in ({pushbutton_input, comparator_trip, low_voltage_detect,
                    port_c_upper_pins[3:1]}),
        .sync_out ({misc_sync, pc_sync[3:1]})
    );

    pirc_sync #(.WIDTH(1)) u_sync_pc0 (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (port_c_upper_pins[0]),
        .sync_out (pc_sync[0])
    );

    assign cmp_sync = misc_sync[1];
    assign lvd_sync = misc_sync[0];

    pirc_sync #(.WIDTH(1)) u_sync_hs (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (high_speed_crystal_mode),
        .sync_out (hs_sync)
    );

    pirc_edge #(.WIDTH(4)) u_pc_edge (
        .clock      (clock),
        .nrst       (nrst),
        .level_in   (pc_sync),
        .rise_out   (),
        .change_out (pc_change)
    );

    // mode level has its own two-stage chain, as deep as the pushbutton path, so both arrive in the same cycle
    pirc_edge #(.WIDTH(3)) u_misc_edge (
        .clock      (clock),
        .nrst       (nrst),
        .level_in   (misc_sync),
        .rise_out   (misc_rise),
        .change_out ()
    );

    // ----------------------------------------
    // bus decode: one wait state, then ack
    // ----------------------------------------
    assign reg_index       = avs_address[9:2];
    assign wr_low          = avs_write & avs_byteenable[0] & ack_reg;
    assign wdat            = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    function is_idx;
        input [7:0] idx;
        input [7:0] want;
        begin
            is_idx = (idx == want);
        end
    endfunction

    always @(posedge clock) begin
        if (!nrst)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // ----------------------------------------
    // flag register: set wins over clear
    // ----------------------------------------
    always @* begin
        peripheral_irq_flags_next = peripheral_irq_flags_reg;
        if (wr_low && is_idx(reg_index, `PIRC_IDX_FLAGS))
            peripheral_irq_flags_next = wdat & `PIRC_IRQ_MASK;
        // events set regardless of any enable
        if (counter_overflow_event)
            peripheral_irq_flags_next[`PIRC_BIT_OVF] = 1'b1;
        if (capture_event)
            peripheral_irq_flags_next[`PIRC_BIT_CAP] = 1'b1;
        if (|pc_change)
            peripheral_irq_flags_next[`PIRC_BIT_PCHG] = 1'b1;
        if (serial_done_event)
            peripheral_irq_flags_next[`PIRC_BIT_SER] = 1'b1;
        if (misc_rise[2] && !hs_sync)
            peripheral_irq_flags_next[`PIRC_BIT_PB] = 1'b1;
        // level-sensitive: held set while trip persists
        if (cmp_sync)
            peripheral_irq_flags_next[`PIRC_BIT_CMP] = 1'b1;
    end

    always @(posedge clock) begin
        if (!nrst) begin
            peripheral_irq_flags_reg   <= `PIRC_RESET_ZERO;
            peripheral_irq_enables_reg <= `PIRC_RESET_ZERO;
            interrupt_control_reg      <= `PIRC_RESET_ZERO;
        end else begin
            peripheral_irq_flags_reg <= peripheral_irq_flags_next & `PIRC_IRQ_MASK;
            if (wr_low && is_idx(reg_index, `PIRC_IDX_ENABLES))
                peripheral_irq_enables_reg <= wdat & `PIRC_IRQ_MASK;
            if (wr_low && is_idx(reg_index, `PIRC_IDX_INTCTL))
                interrupt_control_reg <= wdat & `PIRC_INTCTL_MASK;
        end
    end

    // ----------------------------------------
    // power control: survives non-power-on resets
    // ----------------------------------------
    // por_n is the only reset that clears the power-on flag; nrst alone
    // stands for watchdog or pin resets and leaves it alone
    always @(posedge clock) begin
        if (!por_n) begin
            power_on_flag_reg <= 1'b0;
            reserved_bit_reg  <= 1'b0;
        end else if (wr_low && is_idx(reg_index, `PIRC_IDX_POWER)) begin
            power_on_flag_reg <= wdat[`PIRC_BIT_POR];
            reserved_bit_reg  <= wdat[`PIRC_BIT_RSVD];
        end
    end

    // no reset branch: value after power-on is left undefined
    always @(posedge clock) begin
        if (lvd_sync)
            low_voltage_flag_reg <= 1'b0;
        else if (wr_low && is_idx(reg_index, `PIRC_IDX_POWER))
            low_voltage_flag_reg <= wdat[`PIRC_BIT_LVD];
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        rd_byte = `PIRC_RESET_ZERO;
        case (reg_index)
            `PIRC_IDX_FLAGS:   rd_byte = peripheral_irq_flags_reg;
            `PIRC_IDX_ENABLES: rd_byte = peripheral_irq_enables_reg;
            `PIRC_IDX_INTCTL:  rd_byte = interrupt_control_reg;
            `PIRC_IDX_POWER: begin
                rd_byte[`PIRC_BIT_LVD]  = low_voltage_flag_reg;
                rd_byte[`PIRC_BIT_POR]  = power_on_flag_reg;
                rd_byte[`PIRC_BIT_RSVD] = reserved_bit_reg;
            end
            default:           rd_byte = `PIRC_RESET_ZERO;
        endcase
    end

    always @(posedge clock) begin
        if (!nrst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !ack_reg)
            avs_readdata <= {24'h00_0000, rd_byte};
    end

    // ----------------------------------------
    // core request
    // ----------------------------------------
    always @(posedge clock) begin
        if (!nrst)
            core_irq <= 1'b0;
        else
            core_irq <= (|(peripheral_irq_flags_reg & peripheral_irq_enables_reg))
                        & interrupt_control_reg[`PIRC_BIT_PERIPHERAL_GLOBAL_ENABLE]
                        & interrupt_control_reg[`PIRC_BIT_GIE];
    end
endmodule

// file: src/pirc_regs.vh
`ifndef PIRC_REGS_VH
`define PIRC_REGS_VH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define PIRC_IDX_FLAGS      8'h0c
`define PIRC_IDX_ENABLES    8'h8c
`define PIRC_IDX_POWER      8'h8e
`define PIRC_IDX_INTCTL     8'h8b
// ----------------------------------------
// field positions
// ----------------------------------------
`define PIRC_BIT_OVF        0
`define PIRC_BIT_CAP        1
`define PIRC_BIT_PCHG       2
`define PIRC_BIT_SER        3
`define PIRC_BIT_PB         4
`define PIRC_BIT_CMP        7
`define PIRC_BIT_LVD        0
`define PIRC_BIT_POR        1
`define PIRC_BIT_RSVD       7
`define PIRC_BIT_PERIPHERAL_GLOBAL_ENABLE       6
`define PIRC_BIT_GIE        7
// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define PIRC_IRQ_MASK       8'h9f
`define PIRC_POWER_MASK     8'h83
`define PIRC_INTCTL_MASK    8'hc0
`define PIRC_RESET_ZERO     8'h00
`define PIRC_IDX_LSB        2
`endif

// file: src/pirc_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// two-stage synchroniser, width parameter
// ----------------------------------------
module pirc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge clock) begin
        if (!nrst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// file: src/pirc_edge.v
`timescale 1ns/1ps
// ----------------------------------------
// change detector on synchronised levels
// ----------------------------------------
module pirc_edge #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] rise_out,
    output wire [WIDTH-1:0] change_out
);
    reg [WIDTH-1:0] last_reg;
    reg             armed_reg;

    // no change reported on the first cycle out of reset
    always @(posedge clock) begin
        if (!nrst) begin
            last_reg  <= {WIDTH{1'b0}};
            armed_reg <= 1'b0;
        end else begin
            last_reg  <= level_in;
            armed_reg <= 1'b1;
        end
    end

    assign rise_out   = level_in & ~last_reg & {WIDTH{armed_reg}};
    assign change_out = (level_in ^ last_reg) & {WIDTH{armed_reg}};
endmodule

// file: sim/pirc_monitor.sv
`timescale 1ns/1ps
module pirc_monitor (
    input wire        clock,
    input wire        nrst,
    input wire [9:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        core_irq
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire       rq    = avs_read | avs_write;
    wire       wdone = avs_write & !avs_waitrequest & avs_byteenable[0];
    wire       rdone = avs_read & !avs_waitrequest;
    wire [7:0] idx   = avs_address[9:2];
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_wait_first; rq && !$past(rq) |-> avs_waitrequest; endproperty
    property p_one_wait; rq && avs_waitrequest |=> !avs_waitrequest; endproperty
    property p_gie_off; wdone && idx == 8'h8b && !avs_writedata[7] |-> ##2 !core_irq; endproperty
    property p_peripheral_global_enable_off; wdone && idx == 8'h8b && !avs_writedata[6] |-> ##2 !core_irq; endproperty
    property p_en_off; wdone && idx == 8'h8c && avs_writedata[7:0] == 8'h00 |-> ##2 !core_irq; endproperty
    property p_rd_irq;
        rdone && (idx == 8'h0c || idx == 8'h8c) |=> avs_readdata[31:8] == 24'h00_0000 && avs_readdata[6:5] == 2'b00;
    endproperty
    property p_rd_pwr; rdone && idx == 8'h8e |=> avs_readdata[31:8] == 24'h00_0000 && avs_readdata[6:2] == 5'h00;
    endproperty
    property p_rd_unmap; rdone && !(idx inside {8'h0c, 8'h8c, 8'h8e, 8'h8b}) |=> avs_readdata == 32'h0000_0000;
    endproperty
    property p_rst_irq; disable iff (1'b0) !nrst |=> !core_irq; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state at request start");
    a_one_wait:   assert property (p_one_wait) else $error("wait state longer than one cycle");
    a_gie_off:    assert property (p_gie_off) else $error("request with global enable off");
    a_peripheral_global_enable_off:   assert property (p_peripheral_global_enable_off) else $error("request with peripheral enable off");
    a_en_off:     assert property (p_en_off) else $error("request with all enables off");
    a_rd_irq:     assert property (p_rd_irq) else $error("unimplemented irq bits read nonzero");
    a_rd_pwr:     assert property (p_rd_pwr) else $error("unimplemented power bits read nonzero");
    a_rd_unmap:   assert property (p_rd_unmap) else $error("unmapped read nonzero");
    a_rst_irq:    assert property (p_rst_irq) else $error("request out of reset");
    c_write:      cover property (wdone);
    c_irq:        cover property (core_irq);
    c_pwr:        cover property (rdone && idx == 8'h8e);
endmodule
bind pirc_top pirc_monitor u_mon (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_irq(core_irq));

// file: sim/pirc_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// event sources: fire bit n raises source n
// ----------------------------------------
module pirc_peer (
    input  wire       clock,
    input  wire [7:0] fire,
    output reg        ovf_ev,
    output reg        cap_ev,
    output reg        ser_ev,
    output reg        pb_pin,
    output reg  [3:0] pc_pins,
    output wire       cmp_lvl
);
    initial {ovf_ev, cap_ev, ser_ev, pb_pin, pc_pins} = 8'h00;
    // comparator is a level, held as long as the bench holds bit 7
    assign cmp_lvl = fire[7];
    always @(posedge clock) begin
        ovf_ev  <= fire[0];
        cap_ev  <= fire[1];
        ser_ev  <= fire[3];
        pb_pin  <= fire[4];
        pc_pins <= pc_pins ^ {fire[2], 3'b000};
    end
endmodule

// file: sim/test_pirc_top.sv
`timescale 1ns/1ps
module test_pirc_top;
    reg         clock = 0, nrst = 0, por_n = 0, avs_read = 0, avs_write = 0, hs = 0, low_voltage_flag = 0;
    reg  [9:0]  avs_address = 0;
    reg  [31:0] avs_writedata = 0, seed = 32'h8fe2;
    reg  [3:0]  avs_byteenable = 0;
    reg  [7:0]  fire = 0, acc, en;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, core_irq, ovf, cap, ser, pb, cmp;
    wire [3:0]  pc;
    integer     failures = 0, checked = 0, cycles = 0, i;
    reg  [31:0] exp_q[$], msk_q[$];
    pirc_top u_dut (.clock(clock), .nrst(nrst), .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .counter_overflow_event(ovf),
        .capture_event(cap), .port_c_upper_pins(pc), .serial_done_event(ser), .pushbutton_input(pb),
        .high_speed_crystal_mode(hs), .comparator_trip(cmp), .low_voltage_detect(low_voltage_flag), .core_irq(core_irq));
    pirc_peer u_peer (.clock(clock), .fire(fire), .ovf_ev(ovf), .cap_ev(cap), .ser_ev(ser), .pb_pin(pb),
        .pc_pins(pc), .cmp_lvl(cmp));
    // ----------------------------------------
    // clock, sampled wait state, timeout
    // ----------------------------------------
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            summarize;
        end
    end
    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    task check(input [31:0] seen, input [31:0] want);
        checked = checked + 1;
        if (seen !== want) begin
            failures = failures + 1;
            $display("Error %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // masked bits cover the undefined low-voltage flag
    task bus(input w, input [9:0] a, input [7:0] d, input [3:0] be, input [7:0] e, input [7:0] m);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        if (!w) begin
            exp_q.push_back({24'h00_0000, e});
            msk_q.push_back({24'hff_ffff, m});
        end
        do @(posedge clock); while (avs_waitrequest);
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task pulse(input [7:0] v);
        @(posedge clock) fire <= v;
        @(posedge clock) fire <= v & 8'h80;
        repeat (5) @(posedge clock);
    endtask
    task irq(input [7:0] c, input [31:0] want);
        bus(1, 10'h22c, c, 4'h1, 0, 0);
        repeat (3) @(posedge clock);
        check(core_irq, want);
    endtask
    task summarize;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge clock) if (avs_read && !avs_waitrequest) begin
        check(avs_readdata & msk_q[0], exp_q[0] & msk_q[0]);
        exp_q.pop_front();
        msk_q.pop_front();
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1;
        por_n <= 1;
        bus(0, 10'h030, 0, 0, 8'h00, 8'hff);
        bus(0, 10'h230, 0, 0, 8'h00, 8'hff);
        bus(0, 10'h238, 0, 0, 8'h00, 8'hfe);
        bus(1, 10'h230, 8'hff, 4'h1, 0, 0);
        bus(0, 10'h230, 0, 0, 8'h9f, 8'hff);
        bus(1, 10'h030, 8'hff, 4'h1, 0, 0);
        bus(0, 10'h030, 0, 0, 8'h9f, 8'hff);
        bus(1, 10'h230, 8'h00, 4'h1, 0, 0);
        bus(1, 10'h030, 8'h00, 4'h1, 0, 0);
        bus(1, 10'h030, 8'hff, 4'h0, 0, 0);
        bus(0, 10'h030, 0, 0, 8'h00, 8'hff);
        bus(0, 10'h100, 0, 0, 8'h00, 8'hff);
        hs <= 1;
        pulse(8'h10);
        bus(0, 10'h030, 0, 0, 8'h00, 8'hff);
        hs <= 0;
        acc = 0;
        // enables and control stay zero: flags must still set
        for (i = 0; i < 8; i = i + 1) if (8'h9f & (8'h01 << i)) begin
            pulse(8'h01 << i | (acc & 8'h80));
            acc = acc | (8'h01 << i);
            bus(0, 10'h030, 0, 0, acc, 8'hff);
        end
        @(posedge clock) fire <= 0;
        seed = xs(seed);
        en = (seed[7:0] & 8'h9f) | 8'h01;
        bus(1, 10'h230, en, 4'h1, 0, 0);
        irq(8'hc0, 1);
        irq(8'h80, 0);
        irq(8'h40, 0);
        bus(1, 10'h030, 8'h00, 4'h1, 0, 0);
        irq(8'hc0, 0);
        bus(1, 10'h238, 8'h03, 4'h1, 0, 0);
        bus(0, 10'h238, 0, 0, 8'h03, 8'hff);
        @(posedge clock) low_voltage_flag <= 1;
        repeat (4) @(posedge clock);
        low_voltage_flag <= 0;
        repeat (4) @(posedge clock);
        bus(0, 10'h238, 0, 0, 8'h02, 8'hff);
        nrst <= 0;
        repeat (3) @(posedge clock);
        nrst <= 1;
        bus(0, 10'h238, 0, 0, 8'h02, 8'hff);
        nrst <= 0;
        por_n <= 0;
        repeat (3) @(posedge clock);
        nrst <= 1;
        por_n <= 1;
        bus(0, 10'h238, 0, 0, 8'h00, 8'hfe);
        repeat (3) @(posedge clock);
        check(exp_q.size(), 0);
        summarize;
    end
endmodule
